// >>> common/can_status_cfg.svh
// What this block does
// - Read-only five-bit payload compare count; zero off, 10001 longest, above invalid.
// - Read-only five-bit index of matching acceptance filter, 0 to 15.
// - Code reads 1000100 near full, 1000011 overflow, 1000010 wake, 1000001 error.
// - Buffer event code equals buffer index, 0 to 15; 16 to 63 reserved.
// - Writable three-bit shared buffer count select; 111 reserved.
// - Writable five-bit first buffer index of the receive queue.
// - Read-only six-bit pointer to the queue buffer written next.
// - Read-only six-bit pointer to the queue buffer software reads next.
// - Status bit high while transmitter is bus-off.
// - Status bit high while transmitter is error-passive.
// - Status bit high while receiver is error-passive.
// - Status bit high while transmitter is in error-warning.
// - Status bit high while receiver is in error-warning.
// - Summary bit high when either side is in error-warning.
// - Error flag raised by any of the six error-state sources.
// - Hardware sets flags; software clears by writing 0, writing 1 does nothing.
// - Sticky flag on invalid message received.
// - Sticky flag on wake-up activity on the bus.
// - Sticky flag when the receive queue becomes almost full.
// - Sticky flag on receive buffer overflow.
// - Sticky flags on receive and transmit buffer events until cleared.
// - Interrupt request only when a flag and its enable are both set.
`ifndef CAN_STATUS_CFG_SVH
`define CAN_STATUS_CFG_SVH
// Register byte offsets
`define OFF_CMP_LEN   8'h00
`define OFF_CODE      8'h04
`define OFF_AREA      8'h08
`define OFF_QPTR      8'h0c
`define OFF_FLAGS     8'h10
`define OFF_ENABLES   8'h14
// Flag bit positions in the low byte of the flag register
`define FLAG_INVALID  3'h7
`define FLAG_WAKE     3'h6
`define FLAG_ERR      3'h5
`define FLAG_NEAR     3'h3
`define FLAG_OVF      3'h2
`define FLAG_RXB      3'h1
`define FLAG_TXB      3'h0
`define FLAG_MASK     8'hef
// Reset values
`define PENDING_SOURCE_CODE_NONE    7'h40
`define RST_BUF_SEL   3'h0
`define RST_START     5'h00
// Interrupt codes
`define PENDING_SOURCE_CODE_ERR     7'h41
`define PENDING_SOURCE_CODE_WAKE    7'h42
`define PENDING_SOURCE_CODE_OVF     7'h43
`define PENDING_SOURCE_CODE_NEAR    7'h44
// Limits
`define CMP_MAX       5'h11
`define FILT_MAX      5'h0f
`define BUF_SEL_RSVD  3'h7
`define WARN_LIMIT    8'h60
`define PASSIVE_LIMIT 8'h80
// Bus responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// >>> common/can_status_pkg.sv
package can_status_pkg;

  // AXI4-Lite requests from the master
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_type;

  // AXI4-Lite answers of the slave
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_type;

  // Events and levels from the rest of the controller
  typedef struct packed {
    logic       filter_hit;
    logic [4:0] filter_index;
    logic       rx_buffer_event;
    logic [3:0] rx_buffer_index;
    logic       tx_buffer_event;
    logic [2:0] tx_buffer_index;
    logic       invalid_message;
    logic       wake_activity;
    logic       queue_near_full;
    logic       rx_overflow;
    logic       queue_written;
    logic       queue_read;
    logic       tx_bus_off;
    logic [7:0] tx_error_count;
    logic [7:0] rx_error_count;
    logic [4:0] payload_bit_compare_count;
  } unit_events_type;

  // Whole state of the block
  typedef struct packed {
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [4:0]  cmp_count;
    logic [4:0]  filt_idx;
    logic [6:0]  pending_source_code;
    logic [2:0]  buf_sel;
    logic [4:0]  start_idx;
    logic [5:0]  wr_ptr;
    logic [5:0]  rd_ptr;
    logic [5:0]  err_state;
    logic [7:0]  flags;
    logic [7:0]  enables;
    logic [2:0]  tx_idx;
    logic [3:0]  rx_idx;
    logic        irq;
  } regs_type;

endpackage

// >>> rtl/can_status_interrupt_fifo_regs.sv
`timescale 1ns/1ps
`include "can_status_cfg.svh"
module can_status_interrupt_fifo_regs import can_status_pkg::*; (
  input  wire logic            sys_clk,
  input  wire logic            arst_n,
  input  wire axi_req_type     axi_req,
  output axi_rsp_type          axi_rsp,
  input  wire unit_events_type unit_ev,
  output logic [2:0]           shared_buffer_count_sel,
  output logic [4:0]           queue_start_index,
  output logic                 irq_request
);

  logic [1:0]  rst_sync_q;
  logic        rst_n;
  regs_type    s_q;
  regs_type    s_d;
  logic [5:0]  err_now;
  logic        wr_go;
  logic        wr_ok;
  logic        area_wr;
  logic        flags_wr;
  logic        enables_wr;
  logic [7:0]  keep_mask;
  logic [7:0]  set_mask;
  logic [7:0]  pending;
  logic [5:0]  buf_count;
  logic [31:0] rd_word;
  logic        rd_ok;

  // Buffer count in shared memory for a select code
  function automatic logic [5:0] count_of(input logic [2:0] sel);
    case (sel)
      3'h0:    count_of = 6'h04;
      3'h1:    count_of = 6'h06;
      3'h2:    count_of = 6'h08;
      3'h3:    count_of = 6'h0c;
      3'h4:    count_of = 6'h10;
      3'h5:    count_of = 6'h18;
      default: count_of = 6'h20;
    endcase
  endfunction

  // Next queue buffer, wrapping from the last buffer back to the start
  function automatic logic [5:0] next_ptr(input logic [5:0] p, input logic [5:0] cnt,
                                          input logic [4:0] start);
    if ((p + 6'h01) >= cnt) begin
      next_ptr = {1'b0, start};
    end else begin
      next_ptr = p + 6'h01;
    end
  endfunction

  // Release of the asynchronous reset through two flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Error states from the error counters
  always_comb begin
    err_now[5] = unit_ev.tx_bus_off;
    err_now[4] = !unit_ev.tx_bus_off
                 && (unit_ev.tx_error_count >= `PASSIVE_LIMIT);
    err_now[3] = unit_ev.rx_error_count >= `PASSIVE_LIMIT;
    err_now[2] = unit_ev.tx_error_count >= `WARN_LIMIT;
    err_now[1] = unit_ev.rx_error_count >= `WARN_LIMIT;
    err_now[0] = err_now[2] | err_now[1];
  end

  // Write decode, done once address and data are both held
  always_comb begin
    wr_go      = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    area_wr    = wr_go && (s_q.aw_addr == `OFF_AREA);
    flags_wr   = wr_go && (s_q.aw_addr == `OFF_FLAGS) && s_q.w_strb[0];
    enables_wr = wr_go && (s_q.aw_addr == `OFF_ENABLES) && s_q.w_strb[0];
    wr_ok      = (s_q.aw_addr == `OFF_CMP_LEN) || (s_q.aw_addr == `OFF_CODE)
                 || (s_q.aw_addr == `OFF_AREA) || (s_q.aw_addr == `OFF_QPTR)
                 || (s_q.aw_addr == `OFF_FLAGS) || (s_q.aw_addr == `OFF_ENABLES);
  end

  // Read mux over the register map
  always_comb begin
    rd_word = 32'h0;
    rd_ok   = 1'b1;
    case (axi_req.araddr)
      `OFF_CMP_LEN: rd_word = {27'h0, s_q.cmp_count};
      `OFF_CODE:    rd_word = {19'h0, s_q.filt_idx, 1'b0, s_q.pending_source_code};
      `OFF_AREA:    rd_word = {16'h0, s_q.buf_sel, 8'h0, s_q.start_idx};
      `OFF_QPTR:    rd_word = {18'h0, s_q.wr_ptr, 2'h0, s_q.rd_ptr};
      `OFF_FLAGS:   rd_word = {18'h0, s_q.err_state, s_q.flags};
      `OFF_ENABLES: rd_word = {24'h0, s_q.enables};
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // Flag update: write-zero clear first, then hardware sets on top
  always_comb begin
    keep_mask = flags_wr ? s_q.w_data[7:0] : 8'hff;
    set_mask  = 8'h0;
    set_mask[`FLAG_INVALID] = unit_ev.invalid_message;
    set_mask[`FLAG_WAKE]    = unit_ev.wake_activity;
    set_mask[`FLAG_ERR]     = |(err_now & ~s_q.err_state);
    set_mask[`FLAG_NEAR]    = unit_ev.queue_near_full;
    set_mask[`FLAG_OVF]     = unit_ev.rx_overflow;
    set_mask[`FLAG_RXB]     = unit_ev.rx_buffer_event;
    set_mask[`FLAG_TXB]     = unit_ev.tx_buffer_event;
    buf_count = count_of(s_q.buf_sel);
  end

  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    // Write address and data channels, taken in either order
    if (axi_req.awvalid && !s_q.aw_full) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_q.w_full) begin
      s_d.w_full = 1'b1;
      s_d.w_data = axi_req.wdata;
      s_d.w_strb = axi_req.wstrb;
    end
    if (wr_go) begin
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end
    // Read channel, one read under way at a time
    if (axi_req.arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word;
      s_d.rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    // Status captured from the rest of the controller
    s_d.cmp_count = unit_ev.payload_bit_compare_count;
    if (unit_ev.filter_hit && (unit_ev.filter_index <= `FILT_MAX)) begin
      s_d.filt_idx = unit_ev.filter_index;
    end
    s_d.err_state = err_now;
    // Queue pointers walk the queue area and wrap at the buffer count
    if (unit_ev.queue_written) begin
      s_d.wr_ptr = next_ptr(s_q.wr_ptr, buf_count, s_q.start_idx);
    end
    if (unit_ev.queue_read) begin
      s_d.rd_ptr = next_ptr(s_q.rd_ptr, buf_count, s_q.start_idx);
    end
    // Area control write to the low byte restarts the queue at its new start buffer
    if (area_wr) begin
      if (s_q.w_strb[1] && (s_q.w_data[15:13] != `BUF_SEL_RSVD)) begin
        s_d.buf_sel = s_q.w_data[15:13];
      end
      if (s_q.w_strb[0]) begin
        s_d.start_idx = s_q.w_data[4:0];
        s_d.wr_ptr    = {1'b0, s_q.w_data[4:0]};
        s_d.rd_ptr    = {1'b0, s_q.w_data[4:0]};
      end
    end
    if (enables_wr) begin
      s_d.enables = s_q.w_data[7:0] & `FLAG_MASK;
    end
    s_d.flags = ((s_q.flags & keep_mask) | set_mask) & `FLAG_MASK;
    // Buffer indices behind the buffer flags
    if (unit_ev.rx_buffer_event) begin
      s_d.rx_idx = unit_ev.rx_buffer_index;
    end
    if (unit_ev.tx_buffer_event) begin
      s_d.tx_idx = unit_ev.tx_buffer_index;
    end
    // Code of the highest-priority enabled pending source; the invalid-message flag has no code and leaves the code idle
    pending = s_d.flags & s_d.enables;
    if (pending[`FLAG_ERR]) begin
      s_d.pending_source_code = `PENDING_SOURCE_CODE_ERR;
    end else if (pending[`FLAG_WAKE]) begin
      s_d.pending_source_code = `PENDING_SOURCE_CODE_WAKE;
    end else if (pending[`FLAG_OVF]) begin
      s_d.pending_source_code = `PENDING_SOURCE_CODE_OVF;
    end else if (pending[`FLAG_NEAR]) begin
      s_d.pending_source_code = `PENDING_SOURCE_CODE_NEAR;
    end else if (pending[`FLAG_TXB]) begin
      s_d.pending_source_code = {4'h0, s_d.tx_idx};
    end else if (pending[`FLAG_RXB]) begin
      s_d.pending_source_code = {3'h0, s_d.rx_idx};
    end else begin
      s_d.pending_source_code = `PENDING_SOURCE_CODE_NONE;
    end
    s_d.irq = |pending;
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.pending_source_code     <= `PENDING_SOURCE_CODE_NONE;
      s_q.buf_sel   <= `RST_BUF_SEL;
      s_q.start_idx <= `RST_START;
    end else begin
      s_q <= s_d;
    end
  end

  // Ports from the state
  always_comb begin
    axi_rsp.awready = !s_q.aw_full;
    axi_rsp.wready  = !s_q.w_full;
    axi_rsp.bvalid  = s_q.bvalid;
    axi_rsp.bresp   = s_q.bresp;
    axi_rsp.arready = !s_q.rvalid;
    axi_rsp.rvalid  = s_q.rvalid;
    axi_rsp.rdata   = s_q.rdata;
    axi_rsp.rresp   = s_q.rresp;
    shared_buffer_count_sel = s_q.buf_sel;
    queue_start_index       = s_q.start_idx;
    irq_request             = s_q.irq;
  end

  default clocking main_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence clear_wake_s;
    flags_wr && !s_q.w_data[`FLAG_WAKE];
  endsequence

  sequence wake_event_s;
    unit_ev.wake_activity;
  endsequence

  wake_flag_a: assert property (wake_event_s |=> s_q.flags[`FLAG_WAKE])
    else $error("wake flag not set after activity");
  set_wins_a: assert property (clear_wake_s and wake_event_s |=> s_q.flags[`FLAG_WAKE])
    else $error("clear beat a simultaneous wake event");
  clear_works_a: assert property (clear_wake_s and !unit_ev.wake_activity |=>
                                  !s_q.flags[`FLAG_WAKE])
    else $error("write of zero did not clear wake flag");
  invalid_flag_a: assert property (unit_ev.invalid_message |=> s_q.flags[`FLAG_INVALID])
    else $error("invalid message flag not set");
  near_full_a: assert property (unit_ev.queue_near_full |=> s_q.flags[`FLAG_NEAR])
    else $error("near full flag not set");
  overflow_flag_a: assert property (unit_ev.rx_overflow |=> s_q.flags[`FLAG_OVF])
    else $error("overflow flag not set");
  rx_buffer_a: assert property (unit_ev.rx_buffer_event |=> s_q.flags[`FLAG_RXB]
                                && s_q.rx_idx == $past(unit_ev.rx_buffer_index))
    else $error("rx buffer flag or index wrong");
  bus_off_a: assert property (1'b1 |=> s_q.err_state[5] == $past(unit_ev.tx_bus_off))
    else $error("bus-off bit does not follow transmitter");
  warn_sum_a: assert property (s_q.err_state[0] == (s_q.err_state[2] | s_q.err_state[1]))
    else $error("warning summary mismatch");
  err_rise_a: assert property ((|(err_now & ~s_q.err_state)) |=> s_q.flags[`FLAG_ERR])
    else $error("error flag not raised on new error state");
  irq_gate_a: assert property (irq_request == |(s_q.flags & s_q.enables))
    else $error("interrupt request not flag and enable");
  no_pending_a: assert property (!(|(s_q.flags & s_q.enables)) |->
                                 s_q.pending_source_code == `PENDING_SOURCE_CODE_NONE)
    else $error("code not idle with nothing pending");
  rsvd_sel_a: assert property (area_wr && s_q.w_strb[1]
                               && s_q.w_data[15:13] == `BUF_SEL_RSVD |=> $stable(s_q.buf_sel))
    else $error("reserved buffer count code accepted");

endmodule // can_status_interrupt_fifo_regs

// >>> verification/can_unit_model.sv
`timescale 1ns/1ps
module can_unit_model import can_status_pkg::*; (
  input  wire logic       sys_clk,
  output unit_events_type ev
);
  // Quiet unit until the bench asks for events
  initial ev = '0;

  // Strobe set; bits: hit, rx, tx, invalid, wake, near, ovf, written, read
  task automatic drive(input logic [8:0] w, input logic [4:0] idx);
    ev.filter_hit      <= w[0];
    ev.rx_buffer_event <= w[1];
    ev.tx_buffer_event <= w[2];
    ev.invalid_message <= w[3];
    ev.wake_activity   <= w[4];
    ev.queue_near_full <= w[5];
    ev.rx_overflow     <= w[6];
    ev.queue_written   <= w[7];
    ev.queue_read      <= w[8];
    ev.filter_index    <= idx;
    ev.rx_buffer_index <= idx[3:0];
    ev.tx_buffer_index <= idx[2:0];
  endtask

  // One-cycle pulse, released at the next edge
  task automatic pulse(input logic [8:0] w, input logic [4:0] idx);
    @(posedge sys_clk);
    drive(w, idx);
    @(posedge sys_clk);
    drive(9'h000, idx);
  endtask

  // Error counters, bus-off and compare count are levels
  task automatic levels(input logic [7:0] tx, input logic [7:0] rx, input logic off,
                        input logic [4:0] cmp);
    @(posedge sys_clk);
    ev.tx_error_count            <= tx;
    ev.rx_error_count            <= rx;
    ev.tx_bus_off                <= off;
    ev.payload_bit_compare_count <= cmp;
  endtask
endmodule // can_unit_model

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb import can_status_pkg::*; ;
  logic            sys_clk;
  logic            arst_n;
  logic            irq;
  axi_req_type     req;
  axi_rsp_type     rsp;
  unit_events_type ev;
  logic [2:0]      sel;
  logic [4:0]      start;
  int              n_errors;
  int              checks;

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  can_status_interrupt_fifo_regs u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .axi_req(req),
    .axi_rsp(rsp), .unit_ev(ev), .shared_buffer_count_sel(sel), .queue_start_index(start),
    .irq_request(irq));
  can_unit_model u_model (.sys_clk(sys_clk), .ev(ev));

  task automatic final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tmo;
    n_errors++;
    $display("wrong value handshake expected answer seen none");
    final_report();
  endtask

  // Bus write; address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    if (n == 40) tmo();
    req.bready <= 1'b0;
    chk("bresp", 32'(er), 32'(rsp.bresp));
  endtask

  // Bus read, then compare data and response
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    if (n == 40) tmo();
    chk(nm, e, rsp.rdata);
    chk("rresp", 32'(er), 32'(rsp.rresp));
    req.rready <= 1'b0;
  endtask

  task automatic t_reset;
    logic [7:0]  ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] rv [6] = '{32'h0, 32'h40, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) rc("reset value", ofs[i], rv[i], 2'h0);
    wr(8'h10, 32'hff, 4'hf, 2'h0);
    rc("flags", 8'h10, 32'h0, 2'h0);
    wr(8'h00, 32'h1f, 4'hf, 2'h0);
    rc("compare length", 8'h00, 32'h0, 2'h0);
    wr(8'h18, 32'h1, 4'hf, 2'h2);
    rc("unmapped", 8'h18, 32'h0, 2'h2);
    $display("test reset done");
  endtask

  task automatic t_area;
    for (int k = 0; k < 7; k++) begin
      wr(8'h08, {16'h0, k[2:0], 13'h06}, 4'h3, 2'h0);
      rc("area", 8'h08, {16'h0, k[2:0], 13'h06}, 2'h0);
      chk("count sel port", 32'(k), 32'(sel));
    end
    wr(8'h08, 32'h4006, 4'h3, 2'h0);
    chk("start port", 32'h6, 32'(start));
    rc("pointers", 8'h0c, 32'h0606, 2'h0);
    u_model.pulse(9'h080, 5'h0);
    rc("write ptr", 8'h0c, 32'h0706, 2'h0);
    u_model.pulse(9'h080, 5'h0);
    rc("write ptr wrap", 8'h0c, 32'h0606, 2'h0);
    u_model.pulse(9'h100, 5'h0);
    rc("read ptr", 8'h0c, 32'h0607, 2'h0);
    wr(8'h08, 32'he01f, 4'h3, 2'h0);
    rc("reserved sel", 8'h08, 32'h401f, 2'h0);
    rc("pointers top", 8'h0c, 32'h1f1f, 2'h0);
    $display("test area done");
  endtask

  task automatic t_flags;
    logic [8:0] wm [6] = '{9'h008, 9'h010, 9'h020, 9'h040, 9'h004, 9'h002};
    logic [4:0] ix [6] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h05, 5'h0c};
    logic [7:0] fb [6] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h01, 8'h02};
    logic [6:0] cd [6] = '{7'h40, 7'h42, 7'h44, 7'h43, 7'h05, 7'h0c};
    wr(8'h14, 32'hef, 4'h1, 2'h0);
    rc("enables", 8'h14, 32'hef, 2'h0);
    for (int i = 0; i < 6; i++) begin
      u_model.pulse(wm[i], ix[i]);
      rc("flags", 8'h10, 32'(fb[i]), 2'h0);
      rc("code", 8'h04, 32'(cd[i]), 2'h0);
      chk("irq", 32'h1, 32'(irq));
      wr(8'h10, 32'h0, 4'h1, 2'h0);
      rc("flags cleared", 8'h10, 32'h0, 2'h0);
      chk("irq idle", 32'h0, 32'(irq));
    end
    // Wake and overflow together while masked, then unmasked
    wr(8'h14, 32'h0, 4'h1, 2'h0);
    u_model.pulse(9'h050, 5'h0);
    rc("masked code", 8'h04, 32'h40, 2'h0);
    chk("masked irq", 32'h0, 32'(irq));
    wr(8'h14, 32'hef, 4'h1, 2'h0);
    rc("priority code", 8'h04, 32'h42, 2'h0);
    chk("irq", 32'h1, 32'(irq));
    wr(8'h10, 32'h0, 4'h1, 2'h0);
    // Clear of the wake flag lands in the same cycle as a wake event
    fork
      wr(8'h10, 32'h0, 4'h1, 2'h0);
      begin
        @(posedge sys_clk);
        u_model.pulse(9'h010, 5'h0);
      end
    join
    rc("set wins", 8'h10, 32'h40, 2'h0);
    wr(8'h10, 32'h0, 4'h1, 2'h0);
    $display("test flags done");
  endtask

  task automatic t_errors;
    logic [7:0] tc [6] = '{8'h5f, 8'h60, 8'h00, 8'h80, 8'h00, 8'h00};
    logic [7:0] rn [6] = '{8'h5f, 8'h00, 8'h60, 8'h00, 8'h80, 8'h00};
    logic [5:0] st [6] = '{6'h00, 6'h05, 6'h03, 6'h15, 6'h0b, 6'h20};
    for (int i = 0; i < 6; i++) begin
      u_model.levels(tc[i], rn[i], i == 5, 5'h11);
      rc("error state", 8'h10, {18'h0, st[i], (i > 0) ? 8'h20 : 8'h00}, 2'h0);
    end
    rc("error code", 8'h04, 32'h41, 2'h0);
    chk("irq", 32'h1, 32'(irq));
    rc("compare length", 8'h00, 32'h11, 2'h0);
    u_model.levels(8'h00, 8'h00, 1'b0, 5'h00);
    wr(8'h10, 32'h0, 4'h1, 2'h0);
    rc("error cleared", 8'h10, 32'h0, 2'h0);
    $display("test errors done");
  endtask

  task automatic t_filter;
    u_model.pulse(9'h001, 5'h09);
    rc("filter hit", 8'h04, 32'h0940, 2'h0);
    u_model.pulse(9'h001, 5'h14);
    rc("filter reserved", 8'h04, 32'h0940, 2'h0);
    u_model.pulse(9'h001, 5'h0f);
    rc("filter top", 8'h04, 32'h0f40, 2'h0);
    $display("test filter done");
  endtask

  // Reset for 20 cycles, then the scenarios
  initial begin
    req = '0;
    arst_n = 1'b0;
    n_errors = 0;
    checks = 0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    t_reset();
    t_area();
    t_flags();
    t_errors();
    t_filter();
    final_report();
  end
endmodule // tb
